// ==== hw/bpd_pkg.sv ====
// Notes on behaviour
// - base tick is half the oscillator, about 600 kHz
// - step clock is base tick divided by divider field plus one
// - one output period is sixteen step-clock cycles
// - duty code n gives n+1 active steps of sixteen; 1111 fully active
// - burst unit is 8 ms doubled per duration code, up to 1024 ms
// - started modulation lasts burst unit times repeat count
// - repeat count zero runs until software stops it
// - idle pin rests high for idle bit 0, low for idle bit 1
// - enable write 1 starts, 0 stops; reads 1 while running
// - finished finite burst sets the port-zero event status bit
// - interrupt status clears set bits when read; writes ignored
// - system control bit 3 set gates modulator clock and blocks its registers
package bpd_pkg;

  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned OSC_HZ = 1_200_000;
  localparam int unsigned BASE_HZ = OSC_HZ / 2;
  localparam int unsigned CLK_PER_BASE = CLK_HZ / BASE_HZ;
  localparam int unsigned MS_PERIOD_NS = 1_000_000;
  localparam int unsigned CLK_PER_MS = MS_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned BURST_UNIT_MS = 8;

  localparam logic [7:0] ADDR_SYS_CTRL = 8'h03;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h0a;
  localparam logic [7:0] ADDR_CLOCK_DIV = 8'h50;
  localparam logic [7:0] ADDR_CHAN_CTRL = 8'h51;

  localparam logic [7:0] SYS_CTRL_RESET = 8'h0f;
  localparam logic [7:0] SYS_CTRL_WMASK = 8'h6f;
  localparam int unsigned SYS_PWM_OFF_BIT = 3;
  localparam int unsigned ISR_PORT_ZERO_BIT = 2;
  localparam logic [7:0] CLOCK_DIV_RESET = 8'h00;
  localparam logic [7:0] CHAN_CTRL_RESET = 8'h00;
  localparam logic [3:0] STEP_LAST = 4'hf;

  typedef struct packed {
    logic [2:0] burst_duration_code;
    logic [4:0] div;
  } bpd_clock_div_s;

  typedef struct packed {
    logic [3:0] duty;
    logic [1:0] burst_repeat_count;
    logic idle_low;
    logic enable;
  } bpd_chan_ctrl_s;

  typedef enum logic [0:0] {
    BPD_IDLE = 1'b0,
    BPD_RUN = 1'b1
  } bpd_state_e;

endpackage

// ==== hw/bpd_tick_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
module bpd_tick_gen #(
  parameter int unsigned CYC_PER_MS = bpd_pkg::CLK_PER_MS
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic run_i,
  input wire logic [4:0] div_i,
  output logic step_en_o,
  output logic ms_en_o
);
  import bpd_pkg::*;

  logic [5:0] base_cnt_reg;
  logic [4:0] div_cnt_reg;
  logic [15:0] ms_cnt_reg;
  logic base_en;

  assign base_en = (base_cnt_reg == 6'(CLK_PER_BASE - 1));

  // base tick stands in for the halved oscillator
  always_ff @(posedge clk_i) begin
    if (srst_i || !run_i) begin
      base_cnt_reg <= '0;
    end else if (base_en) begin
      base_cnt_reg <= '0;
    end else begin
      base_cnt_reg <= base_cnt_reg + 6'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i || !run_i) begin
      div_cnt_reg <= '0;
      step_en_o <= 1'b0;
    end else begin
      step_en_o <= base_en && (div_cnt_reg >= div_i);
      if (base_en) begin
        div_cnt_reg <= (div_cnt_reg >= div_i) ? 5'h00 : div_cnt_reg + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i || !run_i) begin
      ms_cnt_reg <= '0;
      ms_en_o <= 1'b0;
    end else begin
      ms_en_o <= (ms_cnt_reg == 16'(CYC_PER_MS - 1));
      ms_cnt_reg <= (ms_cnt_reg == 16'(CYC_PER_MS - 1)) ? 16'h0000 : ms_cnt_reg + 16'h0001;
    end
  end
endmodule // bpd_tick_gen
`default_nettype wire

// ==== hw/bpd_dimmer.sv ====
`timescale 1ns/1ps
`default_nettype none
module bpd_dimmer #(
  parameter int unsigned CYC_PER_MS = bpd_pkg::CLK_PER_MS
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic pwm_o,
  output logic running_o
);
  import bpd_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] sys_ctrl_reg;
  bpd_clock_div_s clock_div_reg;
  bpd_chan_ctrl_s chan_ctrl_reg;
  logic port_zero_event_reg;
  bpd_state_e state_reg;
  logic [3:0] step_reg;
  logic [11:0] burst_ms_reg;
  logic step_en;
  logic ms_en;
  logic gated_off;
  logic pwm_access;
  logic [11:0] burst_unit_ms;
  logic [11:0] burst_total_ms;
  logic burst_done;
  logic start_req;
  logic stop_req;

  assign gated_off = sys_ctrl_reg[SYS_PWM_OFF_BIT];
  assign pwm_access = !gated_off &&
                      (reg_addr_i == ADDR_CLOCK_DIV || reg_addr_i == ADDR_CHAN_CTRL);
  assign start_req = reg_wr_i && pwm_access && reg_addr_i == ADDR_CHAN_CTRL && reg_wdata_i[0];
  assign stop_req = reg_wr_i && pwm_access && reg_addr_i == ADDR_CHAN_CTRL && !reg_wdata_i[0];

  assign burst_unit_ms = 12'(BURST_UNIT_MS) << clock_div_reg.burst_duration_code;
  assign burst_total_ms = 12'(burst_unit_ms * chan_ctrl_reg.burst_repeat_count);
  // repeat count zero never expires
  assign burst_done = (chan_ctrl_reg.burst_repeat_count != 2'b00) && ms_en &&
                      (burst_ms_reg == burst_total_ms - 12'h001);

  ////////////////////////////////////////////////////////////////////////
  // gating is an enable, not a real clock gate, so no glitch hazard
  bpd_tick_gen #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_tick (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .run_i(state_reg == BPD_RUN && !gated_off),
    .div_i(clock_div_reg.div),
    .step_en_o(step_en),
    .ms_en_o(ms_en)
  );

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sys_ctrl_reg <= SYS_CTRL_RESET;
    end else if (reg_wr_i && reg_addr_i == ADDR_SYS_CTRL) begin
      sys_ctrl_reg <= reg_wdata_i & SYS_CTRL_WMASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      clock_div_reg <= CLOCK_DIV_RESET;
    end else if (reg_wr_i && pwm_access && reg_addr_i == ADDR_CLOCK_DIV) begin
      clock_div_reg <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      chan_ctrl_reg <= CHAN_CTRL_RESET;
    end else if (reg_wr_i && pwm_access && reg_addr_i == ADDR_CHAN_CTRL) begin
      chan_ctrl_reg <= reg_wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_reg <= BPD_IDLE;
      burst_ms_reg <= '0;
    end else if (start_req) begin
      state_reg <= BPD_RUN;
      burst_ms_reg <= '0;
    end else if (stop_req) begin
      state_reg <= BPD_IDLE;
    end else if (state_reg == BPD_RUN && burst_done && !gated_off) begin
      state_reg <= BPD_IDLE;
    end else if (state_reg == BPD_RUN && ms_en && !gated_off) begin
      burst_ms_reg <= burst_ms_reg + 12'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i || state_reg == BPD_IDLE) begin
      step_reg <= '0;
    end else if (step_en && !gated_off) begin
      step_reg <= (step_reg == STEP_LAST) ? 4'h0 : step_reg + 4'h1;
    end
  end

  // active portion drives low, suiting a sinking led
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pwm_o <= 1'b1;
    end else if (state_reg == BPD_RUN) begin
      pwm_o <= !(step_reg <= chan_ctrl_reg.duty);
    end else begin
      pwm_o <= !chan_ctrl_reg.idle_low;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      running_o <= 1'b0;
    end else begin
      running_o <= (state_reg == BPD_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // set beats the read-clear; only a bit that was returned is cleared
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      port_zero_event_reg <= 1'b0;
    end else if (state_reg == BPD_RUN && burst_done && !gated_off && !start_req && !stop_req) begin
      port_zero_event_reg <= 1'b1;
    end else if (reg_rd_i && reg_addr_i == ADDR_INT_STATUS) begin
      port_zero_event_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        ADDR_SYS_CTRL: reg_rdata_o <= sys_ctrl_reg;
        ADDR_INT_STATUS: reg_rdata_o <= 8'(port_zero_event_reg) << ISR_PORT_ZERO_BIT;
        ADDR_CLOCK_DIV: reg_rdata_o <= gated_off ? 8'h00 : clock_div_reg;
        ADDR_CHAN_CTRL: reg_rdata_o <= gated_off ? 8'h00 :
                                       {chan_ctrl_reg[7:1], state_reg == BPD_RUN};
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end
endmodule // bpd_dimmer
`default_nettype wire

// ==== verif/bpd_dimmer_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module bpd_dimmer_sva #(
  parameter int unsigned CYC_PER_MS = 20
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic pwm_o,
  input wire logic running_o
);
  logic off_reg;
  logic idle_reg;
  logic cw;
  assign cw = reg_wr_i && reg_addr_i == 8'h51 && !off_reg;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // shadow copies, since the checker cannot peek inside the register file
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      off_reg <= 1'b1;
      idle_reg <= 1'b0;
    end else begin
      if (reg_wr_i && reg_addr_i == 8'h03) off_reg <= reg_wdata_i[3];
      if (cw) idle_reg <= reg_wdata_i[1];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_start_run: assert property (
    cw && reg_wdata_i[0] |-> ##2 running_o) else $error("start ignored");
  a_stop_idle: assert property (
    cw && !reg_wdata_i[0] |-> ##2 !running_o && pwm_o == !$past(reg_wdata_i[1], 2))
    else $error("stop level wrong");
  a_full_duty: assert property (
    cw && reg_wdata_i[7:4] == 4'hf && reg_wdata_i[0] |-> ##2 !pwm_o [*4])
    else $error("full duty broken");
  a_gated_read: assert property (
    reg_rd_i && reg_addr_i[7:1] == 7'h28 && off_reg |-> ##1 reg_rdata_o == 8'h00)
    else $error("gated read not zero");
  a_gated_write: assert property (
    reg_wr_i && reg_addr_i == 8'h51 && off_reg && !running_o && !$past(cw)
    |-> ##2 !running_o) else $error("gated start ran");
  a_isr_clear: assert property (
    reg_rd_i && reg_addr_i == 8'h0a && !running_o ##2 reg_rd_i && reg_addr_i == 8'h0a
    |-> ##1 reg_rdata_o == 8'h00) else $error("status not cleared");
  a_idle_level: assert property (
    !running_o && !$past(running_o) && !$past(reg_wr_i) && !$past(reg_wr_i, 2)
    |-> pwm_o == !idle_reg) else $error("idle level wrong");
  a_end_idle: assert property (
    $fell(running_o) && !$past(reg_wr_i) && !$past(reg_wr_i, 2) |-> pwm_o == !idle_reg)
    else $error("expiry level wrong");
  cover property ($rose(running_o));
  cover property ($fell(running_o));
  cover property (reg_rd_i && reg_addr_i == 8'h0a);
endmodule // bpd_dimmer_sva
bind bpd_dimmer bpd_dimmer_sva #(.CYC_PER_MS(CYC_PER_MS)) u_sva (.clk_i(clk_i), .srst_i(srst_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .pwm_o(pwm_o), .running_o(running_o));
`default_nettype wire

// ==== verif/bpd_led_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module bpd_led_model (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic pwm_i,
  output logic done_o,
  output logic [15:0] len_o
);
  logic [15:0] cnt_reg;
  logic last_reg;
  ////////////////////////////////////////////////////////////////////////////////
  // sinking stage lights while the pin is low; each lit stretch is reported when it ends
  always_ff @(posedge clk_i) begin
    last_reg <= srst_i | pwm_i;
    done_o <= !srst_i && pwm_i && !last_reg;
    len_o <= cnt_reg;
    cnt_reg <= (srst_i || pwm_i) ? 16'h0000 : cnt_reg + 16'h0001;
  end
endmodule // bpd_led_model
`default_nettype wire

// ==== verif/bpd_dimmer_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, (g), (e)); end end
module bpd_dimmer_test;
  import bpd_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic rd_d = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o, rv;
  logic pwm_o, running_o, done;
  logic [15:0] len, pv;
  logic [7:0] rq[$];
  logic [15:0] pq[$];
  logic [3:0] duty;
  logic [4:0] dv;
  int failures = 0, num_checks = 0, cycles = 0, n = 0, seed = 32'h99efc65c;
  bpd_dimmer #(.CYC_PER_MS(20)) u_dut (.clk_i(clk_i), .srst_i(srst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .pwm_o(pwm_o),
    .running_o(running_o));
  bpd_led_model u_led (.clk_i(clk_i), .srst_i(srst_i), .pwm_i(pwm_o), .done_o(done), .len_o(len));
  initial forever #20 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rq.push_back(e);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // read data lands one edge after the strobe, lit stretches as the model reports them
  always @(posedge clk_i) begin
    rd_d <= reg_rd_i;
    cycles <= cycles + 1;
    if (rd_d) begin
      rv = rq.pop_front();
      `CHK(reg_rdata_o, rv)
    end
    if (done) begin
      pv = pq.pop_front();
      `CHK(len, pv)
    end
    if (cycles == 40000) begin
      failures++;
      test_done();
    end
  end
  initial begin
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(8'h03, 8'h0f);
    wr(8'h51, 8'hf1);
    rd(8'h51, 8'h00);
    `CHK(running_o, 1'b0)
    wr(8'h03, 8'h07);
    rd(8'h50, 8'h00);
    rd(8'h51, 8'h00);
    // duty 15 never releases the pin, so the lit-stretch measure needs 0..14
    for (n = 0; n < 3; n++) begin
      duty = 4'($unsigned($random(seed)) % 15);
      dv = 5'($unsigned($random(seed)) % 4);
      wr(8'h50, {3'b000, dv});
      // first step of a burst carries one extra cycle of start latency
      pq.push_back(16'((duty + 1) * (dv + 1) * 41 + 1));
      wr(8'h51, {duty, 4'b0001});
      rd(8'h51, {duty, 4'b0001});
      repeat (3000) if (pq.size() != 0) @(posedge clk_i);
      wr(8'h51, 8'h00);
    end
    for (n = 0; n < 3; n++) begin
      wr(8'h50, {3'(n), 5'h00});
      wr(8'h51, {4'hf, 2'(n + 1), 2'b11});
      repeat ((8 << n) * (n + 1) * 20 - 8) @(posedge clk_i);
      `CHK(running_o, 1'b1)
      repeat (16) @(posedge clk_i);
      `CHK(running_o, 1'b0)
      rd(8'h0a, 8'h04);
      rd(8'h0a, 8'h00);
      rd(8'h51, {4'hf, 2'(n + 1), 2'b10});
    end
    wr(8'h0a, 8'hff);
    rd(8'h0a, 8'h00);
    rd(8'h33, 8'h00);
    wr(8'h51, 8'hf3);
    wr(8'h03, 8'h0f);
    repeat (200) @(posedge clk_i);
    `CHK(running_o, 1'b1)
    rd(8'h51, 8'h00);
    repeat (3) @(posedge clk_i);
    `CHK(pq.size(), 0)
    test_done();
  end
endmodule // bpd_dimmer_test
`default_nettype wire
